/* kvmcs_channel_select.sv */
// How it works
// - Unless emulated, switch auth device power off then on on channel change
// - Auth device host path is its own route, never shared with keyboard or mouse
// - Keyboard key combinations never change the selected channel
// - Only one selection mechanism is listened to at a time
// - Channel indicator is driven continuously, from reset onward
// - Keyboard and mouse always go to the same channel together
// - Filter list changes accepted only from the administrator role
// - Two roles kept, user and administrator; admin functions need admin
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module kvmcs_channel_select #(
    parameter int AUTH_OFF_CYCLES = kvmcs_pkg::AUTH_OFF_CYCLES
) (
    input  wire logic                                    core_clk,
    input  wire logic                                    sys_rst,
    input  wire logic [kvmcs_pkg::REG_ADDR_W-1:0]        regAddr,
    input  wire logic [kvmcs_pkg::REG_DATA_W-1:0]        regWrData,
    input  wire logic                                    regWrEn,
    input  wire logic                                    regRdEn,
    output var  logic [kvmcs_pkg::REG_DATA_W-1:0]        regRdData,
    input  wire kvmcs_pkg::kvmcs_sel_req_type            panelReq,
    input  wire kvmcs_pkg::kvmcs_sel_req_type            remoteReq,
    output var  kvmcs_pkg::kvmcs_km_route_type           kmRoute,
    output var  kvmcs_pkg::kvmcs_auth_route_type         authRoute,
    output var  logic                                    authPowerEn,
    output var  logic [kvmcs_pkg::CHAN_N-1:0]            chanLed
);
    import kvmcs_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [CHAN_N-1:0] chanOneHot(input logic [CHAN_W-1:0] c);
        logic [CHAN_N-1:0] v;
        v    = '0;
        v[c] = 1'b1;
        return v;
    endfunction

    function automatic logic regHit(input logic [REG_ADDR_W-1:0] a,
                                    input logic [REG_ADDR_W-1:0] target);
        return a == target;
    endfunction

    localparam logic [OFF_CNT_W-1:0] OFF_LAST = OFF_CNT_W'(AUTH_OFF_CYCLES - 1);
    localparam logic [CHAN_N-1:0]    LED_RESET = chanOneHot(CHAN_RESET);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [CHAN_W-1:0]     selChan_q;
    kvmcs_src_type         srcSel_q;
    logic                  authEmul_q;
    logic                  adminRole_q;
    logic                  denied_q;
    logic [FILT_IDX_W-1:0] filtIdx_q;
    logic [OFF_CNT_W-1:0]  offCnt_q;
    kvmcs_pwr_type         pwrState_q;
    kvmcs_pwr_type         pwrState_d;
    logic [15:0]           switchCnt_q;
    logic [REG_ADDR_W-1:0] rdAddr_q;
    logic                  rdValid_q;
    logic [REG_DATA_W-1:0] rdHold_q;
    logic [REG_DATA_W-1:0] filtRdData;
    kvmcs_sel_req_type     activeReq;
    logic                  chanChange;
    logic                  offDone;
    logic                  wrCtrl;
    logic                  wrKey;
    logic                  wrIdx;
    logic                  wrFilt;
    logic                  filtWrOk;
    logic                  denyEvent;
    logic                  rdStatus;
    logic [REG_DATA_W-1:0] statusWord;
    logic [REG_DATA_W-1:0] ctrlWord;

    // ---------------------------------------------------------------
    // Register decode
    // ---------------------------------------------------------------
    assign wrCtrl   = regWrEn && regHit(regAddr, ADDR_CTRL);
    assign wrKey    = regWrEn && regHit(regAddr, ADDR_ADMIN_KEY);
    assign wrIdx    = regWrEn && regHit(regAddr, ADDR_FILT_IDX);
    assign wrFilt   = regWrEn && regHit(regAddr, ADDR_FILT_DATA);
    assign rdStatus = regRdEn && regHit(regAddr, ADDR_STATUS);

    assign filtWrOk  = wrFilt && adminRole_q;
    assign denyEvent = (wrFilt || wrCtrl) && !adminRole_q;

    // ---------------------------------------------------------------
    // Roles
    // ---------------------------------------------------------------
    // Role from key match
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            adminRole_q <= 1'b0;
        end else if (wrKey) begin
            adminRole_q <= (regWrData == ADMIN_KEY_DEFAULT);
        end
    end

    // Sticky refusal flag; a new refusal beats the read that clears it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            denied_q <= 1'b0;
        end else if (denyEvent) begin
            denied_q <= 1'b1;
        end else if (rdStatus) begin
            denied_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Configuration
    // ---------------------------------------------------------------
    // Control needs admin
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            srcSel_q   <= SRC_PANEL;
            authEmul_q <= 1'b0;
        end else if (wrCtrl && adminRole_q) begin
            srcSel_q   <= kvmcs_src_type'(regWrData[CTRL_SRC_BIT]);
            authEmul_q <= regWrData[CTRL_EMUL_BIT];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            filtIdx_q <= '0;
        end else if (wrIdx) begin
            filtIdx_q <= regWrData[FILT_IDX_W-1:0];
        end
    end

    kvmcs_filter_mem u_filter_mem (
        .core_clk (core_clk),
        .wrEn     (filtWrOk),
        .wrIdx    (filtIdx_q),
        .wrData   (regWrData),
        .rdIdx    (filtIdx_q),
        .rdData_q (filtRdData)
    );

    // ---------------------------------------------------------------
    // Channel selection
    // ---------------------------------------------------------------
    // No keyboard source wired
    always_comb begin
        unique case (srcSel_q)
            SRC_PANEL:  activeReq = panelReq;
            SRC_REMOTE: activeReq = remoteReq;
        endcase
    end

    assign chanChange = activeReq.valid && (activeReq.chan != selChan_q);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            selChan_q <= CHAN_RESET;
        end else if (chanChange) begin
            selChan_q <= activeReq.chan;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            switchCnt_q <= SW_ZERO;
        end else if (chanChange) begin
            switchCnt_q <= switchCnt_q + SW_ONE;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            kmRoute <= '{kbdChan: CHAN_RESET, mouseChan: CHAN_RESET};
        end else if (chanChange) begin
            kmRoute <= '{kbdChan: activeReq.chan, mouseChan: activeReq.chan};
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chanLed <= LED_RESET;
        end else if (chanChange) begin
            chanLed <= chanOneHot(activeReq.chan);
        end
    end

    // ---------------------------------------------------------------
    // Auth device power cycling
    // ---------------------------------------------------------------
    // Power also cycles after reset, so a token never carries state over
    assign offDone = (offCnt_q == OFF_LAST);

    always_comb begin
        pwrState_d = pwrState_q;
        unique case (pwrState_q)
            PWR_ON: begin
                if (chanChange && !authEmul_q) begin
                    pwrState_d = PWR_OFF;
                end
            end
            PWR_OFF: begin
                if (offDone && !chanChange) begin
                    pwrState_d = PWR_ON;
                end
            end
            default: pwrState_d = PWR_OFF;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwrState_q <= PWR_OFF;
        end else begin
            pwrState_q <= pwrState_d;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            offCnt_q <= CNT_ZERO;
        end else if (chanChange || pwrState_q != PWR_OFF) begin
            offCnt_q <= CNT_ZERO;
        end else if (!offDone) begin
            offCnt_q <= offCnt_q + CNT_ONE;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            authPowerEn <= 1'b0;
        end else begin
            authPowerEn <= (pwrState_d == PWR_ON);
        end
    end

    // Separate auth route
    // Held open while unpowered so no stale session reaches the new host
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            authRoute <= '{connect: 1'b0, chan: CHAN_RESET};
        end else begin
            authRoute.connect <= (pwrState_d == PWR_ON);
            if (chanChange) begin
                authRoute.chan <= activeReq.chan;
            end
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    always_comb begin
        statusWord = ZERO_WORD;
        statusWord[STAT_CHAN_LSB +: CHAN_W] = selChan_q;
        statusWord[STAT_PWR_BIT]   = authPowerEn;
        statusWord[STAT_ADMIN_BIT] = adminRole_q;
        statusWord[STAT_OFF_BIT]   = (pwrState_q == PWR_OFF);
        statusWord[STAT_DENY_BIT]  = denied_q;
        ctrlWord = ZERO_WORD;
        ctrlWord[CTRL_SRC_BIT]  = srcSel_q;
        ctrlWord[CTRL_EMUL_BIT] = authEmul_q;
    end

    // Filter data comes straight out of the memory register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdAddr_q  <= ADDR_CTRL;
            rdValid_q <= 1'b0;
            rdHold_q  <= ZERO_WORD;
        end else begin
            rdAddr_q  <= regAddr;
            rdValid_q <= regRdEn;
            rdHold_q  <= ZERO_WORD;
            if (regRdEn) begin
                unique case (regAddr)
                    ADDR_CTRL:     rdHold_q <= ctrlWord;
                    ADDR_STATUS:   rdHold_q <= statusWord;
                    ADDR_FILT_IDX: rdHold_q <= REG_DATA_W'(filtIdx_q);
                    ADDR_SWITCHES: rdHold_q <= REG_DATA_W'(switchCnt_q);
                    default:       rdHold_q <= ZERO_WORD;
                endcase
            end
        end
    end

    always_comb begin
        if (!rdValid_q) begin
            regRdData = ZERO_WORD;
        end else if (rdAddr_q == ADDR_FILT_DATA) begin
            regRdData = filtRdData;
        end else begin
            regRdData = rdHold_q;
        end
    end

endmodule // kvmcs_channel_select

`default_nettype wire

/* kvmcs_pkg.sv */
`default_nettype none

package kvmcs_pkg;

    // ---------------------------------------------------------------
    // Sizes
    // ---------------------------------------------------------------
    localparam int CHAN_W       = 2;
    localparam int CHAN_N       = 4;
    localparam int REG_ADDR_W   = 4;
    localparam int REG_DATA_W   = 32;
    localparam int FILT_IDX_W   = 4;
    localparam int FILT_DEPTH   = 16;
    localparam int OFF_CNT_W    = 27;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int AUTH_OFF_TIME_MS = 1000;
    localparam int CLK_FREQ_KHZ     = 125000;
    localparam int AUTH_OFF_CYCLES  = AUTH_OFF_TIME_MS * CLK_FREQ_KHZ;

    // ---------------------------------------------------------------
    // Register map (word offsets on the plain port)
    // ---------------------------------------------------------------
    localparam logic [REG_ADDR_W-1:0] ADDR_CTRL      = 4'h0;
    localparam logic [REG_ADDR_W-1:0] ADDR_STATUS    = 4'h1;
    localparam logic [REG_ADDR_W-1:0] ADDR_ADMIN_KEY = 4'h2;
    localparam logic [REG_ADDR_W-1:0] ADDR_FILT_IDX  = 4'h3;
    localparam logic [REG_ADDR_W-1:0] ADDR_FILT_DATA = 4'h4;
    localparam logic [REG_ADDR_W-1:0] ADDR_SWITCHES  = 4'h5;

    // CTRL fields
    localparam int CTRL_SRC_BIT  = 0;
    localparam int CTRL_EMUL_BIT = 1;

    // STATUS fields
    localparam int STAT_CHAN_LSB  = 0;
    localparam int STAT_PWR_BIT   = 2;
    localparam int STAT_ADMIN_BIT = 3;
    localparam int STAT_OFF_BIT   = 4;
    localparam int STAT_DENY_BIT  = 5;

    // Arbitrary value, chosen only for this block
    localparam logic [REG_DATA_W-1:0] ADMIN_KEY_DEFAULT = 32'h5A5AC3C3;

    // Reset values and counter increments
    localparam logic [CHAN_W-1:0]     CHAN_RESET = 2'h0;
    localparam logic [REG_DATA_W-1:0] ZERO_WORD  = 32'h00000000;
    localparam logic [OFF_CNT_W-1:0]  CNT_ZERO   = 27'h0000000;
    localparam logic [OFF_CNT_W-1:0]  CNT_ONE    = 27'h0000001;
    localparam logic [15:0]           SW_ONE     = 16'h0001;
    localparam logic [15:0]           SW_ZERO    = 16'h0000;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic {
        SRC_PANEL  = 1'b0,
        SRC_REMOTE = 1'b1
    } kvmcs_src_type;

    typedef enum logic [1:0] {
        PWR_ON  = 2'b00,
        PWR_OFF = 2'b01
    } kvmcs_pwr_type;

    typedef struct packed {
        logic              valid;
        logic [CHAN_W-1:0] chan;
    } kvmcs_sel_req_type;

    typedef struct packed {
        logic [CHAN_W-1:0] kbdChan;
        logic [CHAN_W-1:0] mouseChan;
    } kvmcs_km_route_type;

    typedef struct packed {
        logic              connect;
        logic [CHAN_W-1:0] chan;
    } kvmcs_auth_route_type;

endpackage : kvmcs_pkg

`default_nettype wire

/* kvmcs_filter_mem.sv */
`timescale 1ns/100ps
`default_nettype none

module kvmcs_filter_mem (
    input  wire logic                                    core_clk,
    input  wire logic                                    wrEn,
    input  wire logic [kvmcs_pkg::FILT_IDX_W-1:0]        wrIdx,
    input  wire logic [kvmcs_pkg::REG_DATA_W-1:0]        wrData,
    input  wire logic [kvmcs_pkg::FILT_IDX_W-1:0]        rdIdx,
    output var  logic [kvmcs_pkg::REG_DATA_W-1:0]        rdData_q
);
    import kvmcs_pkg::*;

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    // No reset so it maps onto plain RAM; software loads it after boot
    logic [REG_DATA_W-1:0] mem [FILT_DEPTH];

    always_ff @(posedge core_clk) begin
        if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
    end

    always_ff @(posedge core_clk) begin
        rdData_q <= mem[rdIdx];
    end

endmodule // kvmcs_filter_mem

`default_nettype wire

/* kvmcs_chan_sel_sva.sv */
`timescale 1ns/100ps
`default_nettype none

module kvmcs_chan_sel_sva #(
    parameter int AUTH_OFF_CYCLES = 20
) (
    input wire logic                               core_clk,
    input wire logic                               sys_rst,
    input wire logic [kvmcs_pkg::REG_DATA_W-1:0]   regRdData,
    input wire logic                               regRdEn,
    input wire kvmcs_pkg::kvmcs_sel_req_type       panelReq,
    input wire kvmcs_pkg::kvmcs_sel_req_type       remoteReq,
    input wire kvmcs_pkg::kvmcs_km_route_type      kmRoute,
    input wire kvmcs_pkg::kvmcs_auth_route_type    authRoute,
    input wire logic                               authPowerEn,
    input wire logic [kvmcs_pkg::CHAN_N-1:0]       chanLed
);
    import kvmcs_pkg::*;
    // ---------------------------------------------------------------
    // Off interval length, counted here since it exceeds a repetition
    // ---------------------------------------------------------------
    int offCnt_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) offCnt_q <= 0;
        else if (authPowerEn) offCnt_q <= 0;
        else offCnt_q <= offCnt_q + 1;
    end

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_km_tied: assert property (kmRoute.kbdChan == kmRoute.mouseChan)
        else $error("keyboard and mouse routes differ");
    a_led_onehot: assert property ($onehot(chanLed))
        else $error("indicator not one-hot");
    a_led_match: assert property (chanLed == (4'h1 << kmRoute.kbdChan))
        else $error("indicator does not show routed channel");
    a_auth_chan: assert property (
        authRoute.connect |-> authRoute.chan == kmRoute.kbdChan)
        else $error("auth route on wrong channel");
    a_connect_pwr: assert property (authRoute.connect |-> authPowerEn)
        else $error("auth device connected while unpowered");
    a_off_min: assert property ($rose(authPowerEn) |-> offCnt_q >= AUTH_OFF_CYCLES)
        else $error("auth power off interval too short");
    a_sel_cause: assert property (
        $changed(kmRoute) |-> $past(panelReq.valid) || $past(remoteReq.valid))
        else $error("route changed without a selection request");
    a_sel_target: assert property ($changed(kmRoute) |->
        ($past(panelReq.valid) && kmRoute.kbdChan == $past(panelReq.chan)) ||
        ($past(remoteReq.valid) && kmRoute.kbdChan == $past(remoteReq.chan)))
        else $error("route changed to an unrequested channel");

    c_power_back: cover property ($rose(authPowerEn));
    c_switch: cover property ($changed(kmRoute));
    c_remote_sel: cover property ($changed(kmRoute) && $past(remoteReq.valid));
    c_read_data: cover property ($past(regRdEn) && regRdData != 32'h0);
endmodule // kvmcs_chan_sel_sva

bind kvmcs_channel_select kvmcs_chan_sel_sva #(.AUTH_OFF_CYCLES(AUTH_OFF_CYCLES)) chk_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .regRdData(regRdData), .regRdEn(regRdEn),
    .panelReq(panelReq), .remoteReq(remoteReq), .kmRoute(kmRoute), .authRoute(authRoute),
    .authPowerEn(authPowerEn), .chanLed(chanLed)
);

`default_nettype wire

/* kvmcs_auth_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// Auth device: reports how long its supply was last held off
// ---------------------------------------------------------------
module kvmcs_auth_dev_model (
    input  wire logic   core_clk,
    input  wire logic   authPowerEn,
    output var  int     offLen
);
    int lowCnt;
    always @(posedge core_clk) begin
        if (!authPowerEn) begin
            lowCnt <= lowCnt + 1;
        end else begin
            if (lowCnt != 0) offLen <= lowCnt;
            lowCnt <= 0;
        end
    end
endmodule // kvmcs_auth_dev_model

`default_nettype wire

/* kvm_channel_select_auth_reset_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module kvm_channel_select_auth_reset_tb;
    import kvmcs_pkg::*;
    // ---------------------------------------------------------------
    // Short off count keeps the run brief
    // ---------------------------------------------------------------
    localparam int OFFN = 20;
    logic                       core_clk, sys_rst, regWrEn, regRdEn, authPowerEn;
    logic [REG_ADDR_W-1:0]      regAddr;
    logic [REG_DATA_W-1:0]      regWrData, regRdData;
    kvmcs_sel_req_type          panelReq, remoteReq;
    kvmcs_km_route_type         kmRoute;
    kvmcs_auth_route_type       authRoute;
    logic [CHAN_N-1:0]          chanLed;
    int                         offLen, badCount, checked, cycles;

    kvmcs_channel_select #(.AUTH_OFF_CYCLES(OFFN)) uut (.core_clk(core_clk),
        .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .panelReq(panelReq), .remoteReq(remoteReq),
        .kmRoute(kmRoute), .authRoute(authRoute), .authPowerEn(authPowerEn), .chanLed(chanLed));
    kvmcs_auth_dev_model dev (.core_clk(core_clk), .authPowerEn(authPowerEn), .offLen(offLen));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            badCount++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1 chk(regRdData & mask, exp);
    endtask
    task automatic sel(input logic rem, input logic [1:0] ch);
        @(posedge core_clk);
        if (rem) remoteReq <= {1'b1, ch};
        else panelReq <= {1'b1, ch};
        @(posedge core_clk);
        panelReq <= 3'h0;
        remoteReq <= 3'h0;
        #1;
    endtask
    task automatic chkRoute(input logic [1:0] ch);
        chk(32'(kmRoute), 32'({ch, ch}));
        chk(32'(chanLed), 32'(4'h1 << ch));
    endtask
    task automatic waitPwr(input int lo, input int hi);
        int n;
        n = 0;
        while (authPowerEn !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1 n++;
        end
        @(posedge core_clk);
        #1 chk(32'(authRoute.connect), 32'h1);
        chk(32'(offLen >= lo && offLen <= hi), 32'h1);
    endtask

    task automatic t_switch();
        sel(1'b0, 2'h2);
        chkRoute(2'h2);
        chk(32'({authPowerEn, authRoute}), 32'h2);
        waitPwr(OFFN, OFFN + 2);
        rdchk(ADDR_STATUS, 32'h7, 32'h6);
        rdchk(ADDR_SWITCHES, 32'hFFFF, 32'h1);
        sel(1'b0, 2'h2);
        chk(32'(authPowerEn), 32'h1);
        sel(1'b0, 2'h3);
        repeat (5) @(posedge core_clk);
        sel(1'b0, 2'h1);
        chkRoute(2'h1);
        waitPwr(OFFN + 5, OFFN + 12);
        rdchk(ADDR_SWITCHES, 32'hFFFF, 32'h3);
        $display("test switch done");
    endtask
    task automatic t_roles();
        wr(ADDR_CTRL, 32'h1);
        rdchk(ADDR_STATUS, 32'h28, 32'h20);
        rdchk(ADDR_STATUS, 32'h28, 32'h0);
        rdchk(ADDR_CTRL, 32'h3, 32'h0);
        sel(1'b1, 2'h0);
        chkRoute(2'h1);
        wr(ADDR_ADMIN_KEY, ADMIN_KEY_DEFAULT);
        rdchk(ADDR_STATUS, 32'h28, 32'h8);
        rdchk(ADDR_ADMIN_KEY, 32'hFFFFFFFF, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        sel(1'b0, 2'h0);
        chkRoute(2'h1);
        sel(1'b1, 2'h2);
        chkRoute(2'h2);
        waitPwr(OFFN, OFFN + 2);
        $display("test roles done");
    endtask
    task automatic t_filter();
        wr(ADDR_FILT_IDX, 32'h5);
        rdchk(ADDR_FILT_IDX, 32'hF, 32'h5);
        wr(ADDR_FILT_DATA, 32'hA5A50F0F);
        rdchk(ADDR_FILT_DATA, 32'hFFFFFFFF, 32'hA5A50F0F);
        wr(ADDR_ADMIN_KEY, 32'h1);
        wr(ADDR_FILT_DATA, 32'h12345678);
        rdchk(ADDR_FILT_DATA, 32'hFFFFFFFF, 32'hA5A50F0F);
        rdchk(ADDR_STATUS, 32'h28, 32'h20);
        rdchk(4'hC, 32'hFFFFFFFF, 32'h0);
        $display("test filter done");
    endtask
    task automatic t_emul();
        wr(ADDR_ADMIN_KEY, ADMIN_KEY_DEFAULT);
        wr(ADDR_CTRL, 32'h3);
        rdchk(ADDR_CTRL, 32'h3, 32'h3);
        sel(1'b1, 2'h3);
        chkRoute(2'h3);
        chk(32'({authPowerEn, authRoute}), 32'hF);
        $display("test emulated done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        {regWrEn, regRdEn, regAddr, regWrData} = '0;
        {panelReq, remoteReq} = '0;
        {badCount, checked, cycles} = '0;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1 chkRoute(2'h0);
        chk(32'({authPowerEn, authRoute}), 32'h0);
        waitPwr(OFFN, OFFN + 16);
        $display("test reset done");
        t_switch();
        t_roles();
        t_filter();
        t_emul();
        close_out();
    end
endmodule // kvm_channel_select_auth_reset_tb

`default_nettype wire
